// >>> inc/sli_pkg.sv
package sli_pkg;
   // Register byte offsets
   localparam logic [7:0] SLI_OFF_CTRL = 8'h00;
   localparam logic [7:0] SLI_OFF_STAT = 8'h04;
   localparam logic [7:0] SLI_OFF_BIST = 8'h08;
   localparam logic [7:0] SLI_OFF_IRQ_STAT = 8'h0C;
   localparam logic [7:0] SLI_OFF_IRQ_MASK = 8'h10;
   localparam logic [7:0] SLI_OFF_TEMP_LIM = 8'h14;
   // Field positions
   localparam int SLI_CTRL_SW_RUN_BIT = 0;
   localparam int SLI_CTRL_FORCE_OFF_BIT = 1;
   localparam int SLI_IRQ_OVT_BIT = 0;
   localparam int SLI_IRQ_FAIL_BIT = 1;
   localparam int SLI_IRQ_LINK_UP_BIT = 2;
   localparam int SLI_IRQ_LINK_DN_BIT = 3;
   localparam int SLI_IRQ_W = 4;
   // Over-temperature flag of the self-test word
   localparam logic [31:0] SLI_BIST_OVT = 32'h0000_0400;
   // Reset values
   localparam logic [1:0] SLI_CTRL_RST = 2'h0;
   localparam logic [SLI_IRQ_W-1:0] SLI_MASK_RST = 4'h0;
   // Temperature in signed whole degrees C
   localparam logic signed [9:0] SLI_TEMP_SHUT_C = 10'sd80;
   // Blink timing: one toggle every half second gives about 1 Hz
   localparam int SLI_CLK_HZ = 250_000_000;
   localparam int SLI_BLINK_HALF_MS = 500;
   localparam int SLI_BLINK_HALF_CYC = SLI_CLK_HZ / 1000 * SLI_BLINK_HALF_MS;
   localparam int SLI_SYNC_STAGES = 2;

   typedef enum logic [2:0]
   {
      SLI_LED_OFF = 3'b000,
      SLI_LED_RED = 3'b001,
      SLI_LED_RED_BLINK = 3'b010,
      SLI_LED_ORANGE_BLINK = 3'b011,
      SLI_LED_GREEN_BLINK = 3'b100,
      SLI_LED_GREEN = 3'b101
   } sli_mode_t;

   typedef struct packed
   {
      logic power_good;
      logic sw_running;
      logic boot_loading;
      logic link_up;
   } sli_cond_t;

   typedef struct packed
   {
      logic red;
      logic green;
   } sli_led_t;
endpackage

// >>> design/sli_sync.sv
`timescale 1ns/100ps
module sli_sync
   import sli_pkg::*;
#(
   parameter int W = 4
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;

   // The first stage feeds only the second
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         meta_r <= '0;
         q <= '0;
      end
      else
      begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule // sli_sync

// >>> design/sli_blink.sv
`timescale 1ns/100ps
module sli_blink
   import sli_pkg::*;
#(
   parameter int HALF_CYC = SLI_BLINK_HALF_CYC
)
(
   input wire logic aclk,
   input wire logic aresetn,
   output logic phase
);
   localparam int CW = $clog2(HALF_CYC + 1);
   localparam logic [CW-1:0] LAST = CW'(HALF_CYC - 1);
   logic [CW-1:0] cnt_r;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cnt_r <= '0;
         phase <= 1'b0;
      end
      else if (cnt_r == LAST)
      begin
         cnt_r <= '0;
         phase <= ~phase;
      end
      else
      begin
         cnt_r <= cnt_r + CW'(1);
      end
   end
endmodule // sli_blink

// >>> design/sli_top.sv
// Notes on behaviour
// - One red/green LED is the only status
// - Dark until power good and software running
// - Steady red on any self-test failure (here over-temperature wins and shows blinking red)
// - Blinking red on over-temperature shutdown
// - Blinking orange while boot code loads
// - Blinking green when link not up
// - Steady green once link established
// - Self-test word, over-temperature at 0x400
// - Shutdown above 80 C stops sensor
// - Dark when input protection cut power
//
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
module sli_top
   import sli_pkg::*;
#(
   parameter int BLINK_HALF_CYC = SLI_BLINK_HALF_CYC
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic power_good,
   input wire logic supply_fault,
   input wire logic boot_loading,
   input wire logic link_up,
   input wire logic [31:0] bist_word,
   input wire logic signed [9:0] temp_c,
   input wire logic [7:0] s_axil_awaddr,
   input wire logic s_axil_awvalid,
   output logic s_axil_awready,
   input wire logic [31:0] s_axil_wdata,
   input wire logic [3:0] s_axil_wstrb,
   input wire logic s_axil_wvalid,
   output logic s_axil_wready,
   output logic [1:0] s_axil_bresp,
   output logic s_axil_bvalid,
   input wire logic s_axil_bready,
   input wire logic [7:0] s_axil_araddr,
   input wire logic s_axil_arvalid,
   output logic s_axil_arready,
   output logic [31:0] s_axil_rdata,
   output logic [1:0] s_axil_rresp,
   output logic s_axil_rvalid,
   input wire logic s_axil_rready,
   output logic led_red,
   output logic led_green,
   output logic sensor_enable,
   output logic lval_enable,
   output logic irq
);
   logic [3:0] pins_s;
   sli_cond_t cond;
   logic blink;
   logic [1:0] ctrl_r;
   logic [31:0] bist_r;
   logic ovt_latch_r;
   logic signed [9:0] temp_lim_r;
   logic [SLI_IRQ_W-1:0] irq_stat_r;
   logic [SLI_IRQ_W-1:0] irq_mask_r;
   logic [SLI_IRQ_W-1:0] irq_ev;
   sli_mode_t mode_r;
   sli_mode_t mode_nxt;
   sli_led_t led_nxt;
   logic link_d_r;
   logic fail_d_r;
   logic ovt_seen_r;
   logic over_hot;
   logic bist_fail;
   logic [7:0] aw_addr_r;
   logic aw_have_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic w_have_r;
   logic do_write;
   logic do_read;
   logic w_ctrl;
   logic w_bist;
   logic w_istat;
   logic w_imask;
   logic w_tlim;

   function automatic logic [31:0] apply_strb(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
         begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      return a == SLI_OFF_CTRL || a == SLI_OFF_STAT || a == SLI_OFF_BIST ||
         a == SLI_OFF_IRQ_STAT || a == SLI_OFF_IRQ_MASK ||
         a == SLI_OFF_TEMP_LIM;
   endfunction

   sli_sync #(
      .W(4)
   ) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      // Each pin is synchronised alone: gating before the flops could glitch
      .d({power_good, supply_fault, boot_loading, link_up}),
      .q(pins_s)
   );

   sli_blink #(
      .HALF_CYC(BLINK_HALF_CYC)
   ) u_blink (
      .aclk(aclk),
      .aresetn(aresetn),
      .phase(blink)
   );

   always_comb
   begin
      cond.power_good = pins_s[3] & ~pins_s[2];
      cond.sw_running = ctrl_r[SLI_CTRL_SW_RUN_BIT];
      cond.boot_loading = pins_s[1];
      cond.link_up = pins_s[0];
   end

   // Temperature is sampled as a settled word by the monitor; latched once
   // exceeded since only a reset recovers from thermal shutdown
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ovt_latch_r <= 1'b0;
      end
      else if (temp_c > temp_lim_r)
      begin
         ovt_latch_r <= 1'b1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bist_r <= '0;
      end
      else
      begin
         bist_r <= (w_bist ? apply_strb(bist_r, w_data_r, w_strb_r) : bist_r)
            | bist_word | (ovt_latch_r ? SLI_BIST_OVT : 32'h0000_0000);
      end
   end

   assign over_hot = (bist_r & SLI_BIST_OVT) != 32'h0000_0000;
   assign bist_fail = (bist_r & ~SLI_BIST_OVT) != 32'h0000_0000;
   assign sensor_enable = ~over_hot;
   assign lval_enable = ~over_hot;

   always_comb
   begin
      if (!cond.power_good || !cond.sw_running ||
         ctrl_r[SLI_CTRL_FORCE_OFF_BIT])
      begin
         mode_nxt = SLI_LED_OFF;
      end
      else if (over_hot)
      begin
         mode_nxt = SLI_LED_RED_BLINK;
      end
      else if (bist_fail)
      begin
         mode_nxt = SLI_LED_RED;
      end
      else if (cond.boot_loading)
      begin
         mode_nxt = SLI_LED_ORANGE_BLINK;
      end
      else if (!cond.link_up)
      begin
         mode_nxt = SLI_LED_GREEN_BLINK;
      end
      else
      begin
         mode_nxt = SLI_LED_GREEN;
      end
   end

   always_comb
   begin
      case (mode_r)
         SLI_LED_RED: led_nxt = '{red: 1'b1, green: 1'b0};
         SLI_LED_RED_BLINK: led_nxt = '{red: blink, green: 1'b0};
         SLI_LED_ORANGE_BLINK: led_nxt = '{red: blink, green: blink};
         SLI_LED_GREEN_BLINK: led_nxt = '{red: 1'b0, green: blink};
         SLI_LED_GREEN: led_nxt = '{red: 1'b0, green: 1'b1};
         default: led_nxt = '{red: 1'b0, green: 1'b0};
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         mode_r <= SLI_LED_OFF;
         led_red <= 1'b0;
         led_green <= 1'b0;
      end
      else
      begin
         mode_r <= mode_nxt;
         led_red <= led_nxt.red;
         led_green <= led_nxt.green;
      end
   end

   // Events
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         link_d_r <= 1'b0;
         fail_d_r <= 1'b0;
      end
      else
      begin
         link_d_r <= cond.link_up;
         fail_d_r <= bist_fail;
      end
   end

   always_comb
   begin
      irq_ev = '0;
      irq_ev[SLI_IRQ_OVT_BIT] = over_hot & ~ovt_seen_r;
      irq_ev[SLI_IRQ_FAIL_BIT] = bist_fail & ~fail_d_r;
      irq_ev[SLI_IRQ_LINK_UP_BIT] = cond.link_up & ~link_d_r;
      irq_ev[SLI_IRQ_LINK_DN_BIT] = ~cond.link_up & link_d_r;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ovt_seen_r <= 1'b0;
      end
      else
      begin
         ovt_seen_r <= over_hot;
      end
   end

   // Set wins over a write-one clear in the same cycle
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         irq_stat_r <= '0;
      end
      else
      begin
         irq_stat_r <= (irq_stat_r & ~(w_istat & w_strb_r[0] ?
            w_data_r[SLI_IRQ_W-1:0] : '0)) | irq_ev;
      end
   end

   assign irq = |(irq_stat_r & irq_mask_r);

   // AXI4-Lite write side: address and data taken in either order
   assign s_axil_awready = ~aw_have_r & ~s_axil_bvalid;
   assign s_axil_wready = ~w_have_r & ~s_axil_bvalid;
   assign do_write = aw_have_r & w_have_r & ~s_axil_bvalid;
   assign w_ctrl = do_write && aw_addr_r == SLI_OFF_CTRL;
   assign w_bist = do_write && aw_addr_r == SLI_OFF_BIST;
   assign w_istat = do_write && aw_addr_r == SLI_OFF_IRQ_STAT;
   assign w_imask = do_write && aw_addr_r == SLI_OFF_IRQ_MASK;
   assign w_tlim = do_write && aw_addr_r == SLI_OFF_TEMP_LIM;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         aw_addr_r <= '0;
         w_data_r <= '0;
         w_strb_r <= '0;
         s_axil_bvalid <= 1'b0;
         s_axil_bresp <= 2'h0;
      end
      else
      begin
         if (s_axil_awvalid && s_axil_awready)
         begin
            aw_have_r <= 1'b1;
            aw_addr_r <= {s_axil_awaddr[7:2], 2'h0};
         end
         if (s_axil_wvalid && s_axil_wready)
         begin
            w_have_r <= 1'b1;
            w_data_r <= s_axil_wdata;
            w_strb_r <= s_axil_wstrb;
         end
         if (do_write)
         begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            s_axil_bvalid <= 1'b1;
            s_axil_bresp <= mapped(aw_addr_r) ? 2'h0 : 2'h2;
         end
         else if (s_axil_bvalid && s_axil_bready)
         begin
            s_axil_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_r <= SLI_CTRL_RST;
         irq_mask_r <= SLI_MASK_RST;
         temp_lim_r <= SLI_TEMP_SHUT_C;
      end
      else
      begin
         if (w_ctrl && w_strb_r[0])
         begin
            ctrl_r <= w_data_r[1:0];
         end
         if (w_imask && w_strb_r[0])
         begin
            irq_mask_r <= w_data_r[SLI_IRQ_W-1:0];
         end
         if (w_tlim)
         begin
            temp_lim_r <= 10'(signed'(apply_strb(32'(temp_lim_r), w_data_r,
               w_strb_r)));
         end
      end
   end

   // Read side
   assign s_axil_arready = ~s_axil_rvalid;
   assign do_read = s_axil_arvalid & s_axil_arready;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axil_rvalid <= 1'b0;
         s_axil_rdata <= '0;
         s_axil_rresp <= 2'h0;
      end
      else if (do_read)
      begin
         s_axil_rvalid <= 1'b1;
         s_axil_rresp <= mapped({s_axil_araddr[7:2], 2'h0}) ? 2'h0 : 2'h2;
         case ({s_axil_araddr[7:2], 2'h0})
            SLI_OFF_CTRL: s_axil_rdata <= {30'h0, ctrl_r};
            SLI_OFF_STAT: s_axil_rdata <= {23'h0, ovt_latch_r, cond, mode_r,
               led_red};
            SLI_OFF_BIST: s_axil_rdata <= bist_r;
            SLI_OFF_IRQ_STAT: s_axil_rdata <= {28'h0, irq_stat_r};
            SLI_OFF_IRQ_MASK: s_axil_rdata <= {28'h0, irq_mask_r};
            SLI_OFF_TEMP_LIM: s_axil_rdata <= {{22{temp_lim_r[9]}},
               temp_lim_r};
            default: s_axil_rdata <= '0;
         endcase
      end
      else if (s_axil_rready)
      begin
         s_axil_rvalid <= 1'b0;
      end
   end

   a_led_off_dark: assert property (@(posedge aclk)
      disable iff (!aresetn) !cond.power_good |-> ##2 !led_red && !led_green)
      else $error("LED lit without power");
   a_fail_red: assert property (@(posedge aclk)
      disable iff (!aresetn) mode_r == SLI_LED_RED |=> led_red && !led_green)
      else $error("Self-test failure not steady red");
   a_hot_priority: assert property (@(posedge aclk)
      disable iff (!aresetn) over_hot && cond.power_good &&
      cond.sw_running && !ctrl_r[SLI_CTRL_FORCE_OFF_BIT] |=>
      mode_r == SLI_LED_RED_BLINK)
      else $error("Over-temperature not shown");
   a_hot_stops: assert property (@(posedge aclk)
      disable iff (!aresetn) temp_c > temp_lim_r |=> ##1
      !sensor_enable && !lval_enable)
      else $error("Sensor not stopped when hot");
   a_bist_ovt: assert property (@(posedge aclk)
      disable iff (!aresetn) ovt_latch_r |=> bist_r[10])
      else $error("Over-temperature flag missing");
   a_green_link: assert property (@(posedge aclk)
      disable iff (!aresetn) mode_r == SLI_LED_GREEN |=>
      led_green && !led_red)
      else $error("Link up not steady green");
   a_green_blink: assert property (@(posedge aclk)
      disable iff (!aresetn) mode_r == SLI_LED_GREEN_BLINK |=>
      !led_red && led_green == $past(blink))
      else $error("Link down not blinking green");
   a_orange_pair: assert property (@(posedge aclk)
      disable iff (!aresetn) mode_r == SLI_LED_ORANGE_BLINK |=>
      led_red == led_green)
      else $error("Orange blink not both colours");
   // A link loss must reach the interrupt even when software clears status
   a_irq_level: assert property (@(posedge aclk)
      disable iff (!aresetn) irq_ev[SLI_IRQ_LINK_DN_BIT] &&
      irq_mask_r[SLI_IRQ_LINK_DN_BIT] && !w_imask |=> irq)
      else $error("Link loss did not raise the interrupt");
   c_green: cover property (@(posedge aclk) mode_r == SLI_LED_GREEN);
   c_orange: cover property (@(posedge aclk)
      mode_r == SLI_LED_ORANGE_BLINK ##1 mode_r == SLI_LED_GREEN_BLINK);
   c_hot: cover property (@(posedge aclk) mode_r == SLI_LED_RED_BLINK);
   c_red: cover property (@(posedge aclk) mode_r == SLI_LED_RED);
endmodule // sli_top

// >>> test/tb_top.sv
`timescale 1ns/100ps
module tb_top
   import sli_pkg::*;
;
   // Short blink half period keeps each blink check to a few dozen cycles
   localparam int BLK = 4;
   localparam logic [1:0] OFF = 2'h0;
   localparam logic [1:0] GRN = 2'h1;
   localparam logic [1:0] RED = 2'h2;
   localparam logic [1:0] ORG = 2'h3;
   logic aclk, aresetn, power_good, supply_fault, boot_loading, link_up;
   logic [31:0] bist_word, s_axil_wdata, s_axil_rdata, bv;
   logic signed [9:0] temp_c;
   logic [7:0] s_axil_awaddr, s_axil_araddr;
   logic [3:0] s_axil_wstrb;
   logic s_axil_awvalid, s_axil_awready, s_axil_wvalid, s_axil_wready;
   logic s_axil_bvalid, s_axil_bready, s_axil_arvalid, s_axil_arready;
   logic s_axil_rvalid, s_axil_rready, led_red, led_green;
   logic sensor_enable, lval_enable, irq;
   logic [1:0] s_axil_bresp, s_axil_rresp;
   logic [15:0] lf;
   int err_total, samples_checked, cyc;

   sli_top #(.BLINK_HALF_CYC(BLK)) dut_u
   (
      .aclk(aclk), .aresetn(aresetn), .power_good(power_good),
      .supply_fault(supply_fault), .boot_loading(boot_loading),
      .link_up(link_up), .bist_word(bist_word), .temp_c(temp_c),
      .s_axil_awaddr(s_axil_awaddr), .s_axil_awvalid(s_axil_awvalid),
      .s_axil_awready(s_axil_awready), .s_axil_wdata(s_axil_wdata),
      .s_axil_wstrb(s_axil_wstrb), .s_axil_wvalid(s_axil_wvalid),
      .s_axil_wready(s_axil_wready), .s_axil_bresp(s_axil_bresp),
      .s_axil_bvalid(s_axil_bvalid), .s_axil_bready(s_axil_bready),
      .s_axil_araddr(s_axil_araddr), .s_axil_arvalid(s_axil_arvalid),
      .s_axil_arready(s_axil_arready), .s_axil_rdata(s_axil_rdata),
      .s_axil_rresp(s_axil_rresp), .s_axil_rvalid(s_axil_rvalid),
      .s_axil_rready(s_axil_rready), .led_red(led_red),
      .led_green(led_green), .sensor_enable(sensor_enable),
      .lval_enable(lval_enable), .irq(irq)
   );

   always #2 aclk = ~aclk;

   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task automatic summarize;
      if (err_total == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] s, e);
      samples_checked++;
      if (s !== e)
      begin
         err_total++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask

   // Sampled late in the cycle so the ready seen is the one at the next edge
   task automatic axw(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er);
      bit ha, hw, hb;
      logic [1:0] r;
      s_axil_awaddr <= a;
      s_axil_awvalid <= 1'b1;
      s_axil_wdata <= d;
      s_axil_wvalid <= 1'b1;
      do
      begin
         #3;
         ha = s_axil_awvalid && s_axil_awready;
         hw = s_axil_wvalid && s_axil_wready;
         hb = s_axil_bvalid;
         r = s_axil_bresp;
         @(posedge aclk);
         if (ha)
            s_axil_awvalid <= 1'b0;
         if (hw)
            s_axil_wvalid <= 1'b0;
      end
      while (!hb);
      chk("bresp", {30'h0, r}, {30'h0, er});
   endtask

   task automatic axr(input logic [7:0] a, input logic [31:0] ed,
      input logic [1:0] er);
      bit ha, hr;
      logic [31:0] d;
      logic [1:0] r;
      s_axil_araddr <= a;
      s_axil_arvalid <= 1'b1;
      do
      begin
         #3;
         ha = s_axil_arvalid && s_axil_arready;
         hr = s_axil_rvalid;
         d = s_axil_rdata;
         r = s_axil_rresp;
         @(posedge aclk);
         if (ha)
            s_axil_arvalid <= 1'b0;
      end
      while (!hr);
      chk("rdata", d, ed);
      chk("rresp", {30'h0, r}, {30'h0, er});
   endtask

   task automatic outs(input logic s, input logic i);
      #3;
      chk("sensor_enable", {31'h0, sensor_enable}, {31'h0, s});
      chk("lval_enable", {31'h0, lval_enable}, {31'h0, s});
      chk("irq", {31'h0, irq}, {31'h0, i});
      @(posedge aclk);
   endtask

   // Blink: every complete run between two toggles must last BLK cycles
   task automatic led_mode(input logic [1:0] e, input bit blink);
      logic [1:0] v, p;
      int run, tr, bad;
      run = 0;
      tr = 0;
      bad = 0;
      repeat (8) @(posedge aclk);
      #3;
      p = {led_red, led_green};
      repeat (24)
      begin
         @(posedge aclk);
         #3;
         v = {led_red, led_green};
         run++;
         if (v !== e && !(blink && v === OFF))
            bad++;
         if (v !== p)
         begin
            if (tr > 0 && run != BLK)
               bad++;
            tr++;
            run = 0;
         end
         p = v;
      end
      @(posedge aclk);
      chk("led_pattern", bad, 0);
      chk("led_toggles", 32'(blink ? tr >= 4 : tr == 0), 32'h1);
   endtask

   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (cyc > 20000)
      begin
         err_total++;
         summarize();
      end
   end

   initial
   begin
      aclk = 1'b0;
      aresetn = 1'b0;
      power_good = 1'b0;
      supply_fault = 1'b0;
      boot_loading = 1'b0;
      link_up = 1'b0;
      bist_word = 32'h0;
      temp_c = 10'sh014;
      s_axil_awaddr = 8'h0;
      s_axil_awvalid = 1'b0;
      s_axil_wdata = 32'h0;
      s_axil_wstrb = 4'hF;
      s_axil_wvalid = 1'b0;
      s_axil_bready = 1'b1;
      s_axil_araddr = 8'h0;
      s_axil_arvalid = 1'b0;
      s_axil_rready = 1'b1;
      lf = 16'h004E;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      outs(1'b1, 1'b0);
      axr(SLI_OFF_CTRL, 32'h0, 2'h0);
      axr(SLI_OFF_IRQ_MASK, 32'h0, 2'h0);
      axr(SLI_OFF_TEMP_LIM, 32'h0000_0050, 2'h0);
      axr(SLI_OFF_BIST, 32'h0, 2'h0);
      axr(8'h18, 32'h0, 2'h2);
      axw(8'h1C, 32'h1, 2'h2);
      axw(SLI_OFF_STAT, 32'hFFFF_FFFF, 2'h0);
      power_good <= 1'b1;
      led_mode(OFF, 1'b0);
      axw(SLI_OFF_CTRL, 32'h1, 2'h0);
      boot_loading <= 1'b1;
      led_mode(ORG, 1'b1);
      link_up <= 1'b1;
      led_mode(ORG, 1'b1);
      boot_loading <= 1'b0;
      led_mode(GRN, 1'b0);
      axr(SLI_OFF_STAT, 32'h0000_00DA, 2'h0);
      outs(1'b1, 1'b0);
      axr(SLI_OFF_IRQ_STAT, 32'h4, 2'h0);
      axw(SLI_OFF_IRQ_MASK, 32'hC, 2'h0);
      outs(1'b1, 1'b1);
      axw(SLI_OFF_IRQ_STAT, 32'h4, 2'h0);
      outs(1'b1, 1'b0);
      link_up <= 1'b0;
      led_mode(GRN, 1'b1);
      outs(1'b1, 1'b1);
      axw(SLI_OFF_IRQ_STAT, 32'h8, 2'h0);
      outs(1'b1, 1'b0);
      repeat (6)
      begin
         lf = lfsr_next(lf);
         temp_c <= $signed({3'h0, lf[6:0] % 7'h79}) - 10'sh028;
         repeat (4) @(posedge aclk);
         outs(1'b1, 1'b0);
      end
      supply_fault <= 1'b1;
      led_mode(OFF, 1'b0);
      supply_fault <= 1'b0;
      power_good <= 1'b0;
      led_mode(OFF, 1'b0);
      power_good <= 1'b1;
      axw(SLI_OFF_IRQ_MASK, 32'hF, 2'h0);
      lf = lfsr_next(lf);
      bv = ({lf, lfsr_next(lf)} & ~SLI_BIST_OVT) | 32'h0000_0001;
      bist_word <= bv;
      boot_loading <= 1'b1;
      link_up <= 1'b1;
      @(posedge aclk);
      bist_word <= 32'h0;
      led_mode(RED, 1'b0);
      axr(SLI_OFF_BIST, bv, 2'h0);
      axr(SLI_OFF_IRQ_STAT, 32'h6, 2'h0);
      outs(1'b1, 1'b1);
      axw(SLI_OFF_IRQ_STAT, 32'hF, 2'h0);
      // Exactly at the limit must not shut down; one degree above must
      temp_c <= 10'sh050;
      repeat (4) @(posedge aclk);
      outs(1'b1, 1'b0);
      temp_c <= 10'sh051;
      repeat (4) @(posedge aclk);
      outs(1'b0, 1'b1);
      led_mode(RED, 1'b1);
      axr(SLI_OFF_BIST, bv | SLI_BIST_OVT, 2'h0);
      axr(SLI_OFF_IRQ_STAT, 32'h1, 2'h0);
      temp_c <= 10'sh014;
      repeat (4) @(posedge aclk);
      outs(1'b0, 1'b1);
      aresetn <= 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      outs(1'b1, 1'b0);
      led_mode(OFF, 1'b0);
      // Force-off keeps dark the state that sw_running would light; clearing it brings the state back
      axw(SLI_OFF_CTRL, 32'h3, 2'h0);
      led_mode(OFF, 1'b0);
      axr(SLI_OFF_CTRL, 32'h3, 2'h0);
      axw(SLI_OFF_CTRL, 32'h1, 2'h0);
      led_mode(ORG, 1'b1);
      axw(SLI_OFF_TEMP_LIM, 32'h0000_0010, 2'h0);
      repeat (4) @(posedge aclk);
      outs(1'b0, 1'b0);
      axr(SLI_OFF_TEMP_LIM, 32'h0000_0010, 2'h0);
      axw(SLI_OFF_BIST, 32'h0000_0001, 2'h0);
      axr(SLI_OFF_BIST, 32'h0000_0401, 2'h0);
      led_mode(RED, 1'b1);
      summarize();
   end
endmodule // tb_top
